// ### verilog/dfm_top.sv
// configuration registers and alarm gating of the reference frequency monitor
`timescale 1ns/1ps
module dfm_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [dfm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dfm_pkg::DATA_W-1:0] wdata_i,
  input wire logic meas_valid_i,
  input wire logic [dfm_pkg::OFS_W-1:0] meas_ofs_i,
  output logic [dfm_pkg::DATA_W-1:0] rdata_o,
  output logic [dfm_pkg::OFS_W-1:0] hold_pull_lim_o,
  output logic hold_pull_unlim_o,
  output logic freq_reject_o,
  output logic ref_fail_o,
  output logic holdover_req_o
);
  import dfm_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] hold_pull;
    logic [7:0] ho_en;
    logic [7:0] rf_en;
    logic [7:0] win_sel;
    logic [7:0] rdata;
    logic [15:0] hold_lim;
    logic hold_unlim;
    logic rej;
    logic ref_fail;
    logic holdover;
  } dfm_state_t;

  dfm_state_t s_q;
  dfm_state_t s_d;
  logic [2:0] hold_code;

  dfm_win_if win_bus ();

  dfm_window u_window (
    .w(win_bus.win)
  );

  assign win_bus.sel = s_q.win_sel[WIN_CODE_LSB +: CODE_W];
  assign win_bus.ofs = meas_ofs_i;
  assign win_bus.prev_rej = s_q.rej;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // whole bytes are stored so reserved bits read back as written
    if (wr_en_i) begin
      unique case (addr_i)
        OFS_HOLD_PULL: s_d.hold_pull = wdata_i;
        OFS_HO_EN: s_d.ho_en = wdata_i;
        OFS_RF_EN: s_d.rf_en = wdata_i;
        OFS_WIN_SEL: s_d.win_sel = wdata_i;
        default: ;
      endcase
    end
    if (rd_en_i) begin
      unique case (addr_i)
        OFS_HOLD_PULL: s_d.rdata = s_q.hold_pull;
        OFS_HO_EN: s_d.rdata = s_q.ho_en;
        OFS_RF_EN: s_d.rdata = s_q.rf_en;
        OFS_WIN_SEL: s_d.rdata = s_q.win_sel;
        default: s_d.rdata = RD_UNMAPPED;
      endcase
    end
    hold_code = s_d.hold_pull[HOLD_CODE_LSB +: CODE_W];
    if (hold_code == HOLD_UNLIMITED) begin
      s_d.hold_unlim = 1'b1;
    // reserved codes keep the last valid range rather than guess one
    end else if (hold_code != HOLD_RSVD_A && hold_code != HOLD_RSVD_B) begin
      s_d.hold_unlim = 1'b0;
      s_d.hold_lim = dfm_hold_lim(hold_code);
    end
    // verdict only moves on a measurement
    if (meas_valid_i) begin
      s_d.rej = win_bus.next_rej;
    end
    // only the defined enable bits gate the alarm
    s_d.holdover = s_d.rej & s_d.ho_en[HO_EN_BIT];
    s_d.ref_fail = s_d.rej & s_d.rf_en[RF_EN_BIT];
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q.hold_pull <= RST_HOLD_PULL;
      s_q.ho_en <= RST_HO_EN;
      s_q.rf_en <= RST_RF_EN;
      s_q.win_sel <= RST_WIN_SEL;
      s_q.rdata <= RD_UNMAPPED;
      s_q.hold_lim <= HOLD_LIM_RST;
      s_q.hold_unlim <= 1'b1;
      s_q.rej <= 1'b0;
      s_q.ref_fail <= 1'b0;
      s_q.holdover <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign hold_pull_lim_o = s_q.hold_lim;
  assign hold_pull_unlim_o = s_q.hold_unlim;
  assign freq_reject_o = s_q.rej;
  assign ref_fail_o = s_q.ref_fail;
  assign holdover_req_o = s_q.holdover;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence wr_win_s;
    wr_en_i && addr_i == OFS_WIN_SEL;
  endsequence

  sequence rd_win_s;
    rd_en_i && !wr_en_i && addr_i == OFS_WIN_SEL;
  endsequence

  unlim_code_a: assert property (
    s_q.hold_pull[2:0] == 3'h7 |-> hold_pull_unlim_o)
    else $error("unlimited code not decoded");

  hold_limit_a: assert property (
    wr_en_i && addr_i == OFS_HOLD_PULL && wdata_i[2:0] == 3'h4 |=>
      hold_pull_lim_o == 16'd4000 && !hold_pull_unlim_o)
    else $error("400 ppm range wrong");

  ho_mask_a: assert property (
    !s_q.ho_en[4] |-> !holdover_req_o)
    else $error("masked alarm forced holdover");

  ho_follow_a: assert property (
    s_q.ho_en[4] |-> holdover_req_o == freq_reject_o)
    else $error("holdover not following alarm");

  rf_gate_a: assert property (
    ref_fail_o == (freq_reject_o && s_q.rf_en[0]))
    else $error("ref fail gating wrong");

  accept_in_a: assert property (
    meas_valid_i && meas_ofs_i <= dfm_acc_lim(s_q.win_sel[2:0]) |=> !freq_reject_o)
    else $error("offset inside acceptance rejected");

  reject_out_a: assert property (
    meas_valid_i && meas_ofs_i > dfm_rej_lim(s_q.win_sel[2:0]) |=> freq_reject_o)
    else $error("offset outside rejection accepted");

  hyst_hold_a: assert property (
    (!meas_valid_i || (meas_ofs_i > dfm_acc_lim(s_q.win_sel[2:0])
      && meas_ofs_i <= dfm_rej_lim(s_q.win_sel[2:0]))) |=> $stable(freq_reject_o))
    else $error("verdict moved in hysteresis band");

  win_edge_a: assert property (
    s_q.win_sel[2:0] == 3'h6 && meas_valid_i && meas_ofs_i == 16'd476 |=> freq_reject_o)
    else $error("47.5 ppm edge wrong");

  win_rdback_a: assert property (
    wr_win_s ##1 rd_win_s |=> rdata_o == $past(wdata_i, 2))
    else $error("window register readback wrong");

  sequence wr_hold_s;
    wr_en_i && addr_i == OFS_HOLD_PULL;
  endsequence

  rst_ho_a: assert property (disable iff (1'b0)
    !resetn_i |=> s_q.ho_en == RST_HO_EN)
    else $error("holdover enable reset value wrong");

  rst_rf_a: assert property (disable iff (1'b0)
    !resetn_i |=> s_q.rf_en == RST_RF_EN)
    else $error("ref fail enable reset value wrong");

  hold_rsvd_a: assert property (
    wr_hold_s ##0 (wdata_i[2:0] == HOLD_RSVD_A || wdata_i[2:0] == HOLD_RSVD_B) |=>
      $stable(hold_pull_lim_o) && $stable(hold_pull_unlim_o))
    else $error("reserved range code changed the range");

  hold_code0_a: assert property (
    wr_hold_s ##0 (wdata_i[2:0] == 3'h0) |=> hold_pull_lim_o == 16'h0078 && !hold_pull_unlim_o)
    else $error("12 ppm range wrong");

  hold_code1_a: assert property (
    wr_hold_s ##0 (wdata_i[2:0] == 3'h1) |=> hold_pull_lim_o == 16'h0208 && !hold_pull_unlim_o)
    else $error("52 ppm range wrong");

  ho_clear_a: assert property (
    wr_en_i && addr_i == OFS_HO_EN && !wdata_i[HO_EN_BIT] |=> !holdover_req_o)
    else $error("cleared holdover enable still forces holdover");

  rf_set_a: assert property (
    wr_en_i && addr_i == OFS_RF_EN && wdata_i[RF_EN_BIT] |=> ref_fail_o == freq_reject_o)
    else $error("set ref fail enable does not pass the alarm");

  rf_clear_a: assert property (
    wr_en_i && addr_i == OFS_RF_EN && !wdata_i[RF_EN_BIT] |=> !ref_fail_o)
    else $error("cleared ref fail enable still passes the alarm");

  rd_hold_a: assert property (
    rd_en_i && addr_i == OFS_HOLD_PULL |=> rdata_o == $past(s_q.hold_pull))
    else $error("range register readback wrong");

  rd_win_a: assert property (
    rd_en_i && addr_i == OFS_WIN_SEL |=> rdata_o == $past(s_q.win_sel))
    else $error("window register read wrong");
endmodule

// ### verilog/dfm_pkg.sv
// constants, register map and window tables of the reference frequency monitor
package dfm_pkg;
  // ------------------------------------------------------------
  // register port widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int OFS_W = 16;

  // ------------------------------------------------------------
  // register offsets and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_HOLD_PULL = 8'hed;
  localparam logic [7:0] OFS_HO_EN = 8'hf4;
  localparam logic [7:0] OFS_RF_EN = 8'hf5;
  localparam logic [7:0] OFS_WIN_SEL = 8'hf7;
  localparam logic [7:0] RST_HOLD_PULL = 8'h07;
  localparam logic [7:0] RST_HO_EN = 8'hf0;
  localparam logic [7:0] RST_RF_EN = 8'h00;
  localparam logic [7:0] RST_WIN_SEL = 8'h33;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int HOLD_CODE_LSB = 0;
  localparam int WIN_CODE_LSB = 0;
  localparam int CODE_W = 3;
  localparam int HO_EN_BIT = 4;
  localparam int RF_EN_BIT = 0;

  // ------------------------------------------------------------
  // limits in units of 0.1 ppm
  // ------------------------------------------------------------
  localparam logic [2:0] HOLD_UNLIMITED = 3'h7;
  localparam logic [2:0] HOLD_RSVD_A = 3'h5;
  localparam logic [2:0] HOLD_RSVD_B = 3'h6;
  localparam logic [15:0] HOLD_LIM_RST = 16'h0000;

  function automatic logic [15:0] dfm_hold_lim(input logic [2:0] code);
    unique case (code)
      3'h0: dfm_hold_lim = 16'd120;
      3'h1: dfm_hold_lim = 16'd520;
      3'h2: dfm_hold_lim = 16'd830;
      3'h3: dfm_hold_lim = 16'd1300;
      default: dfm_hold_lim = 16'd4000;
    endcase
  endfunction

  function automatic logic [15:0] dfm_acc_lim(input logic [2:0] code);
    unique case (code)
      3'h0: dfm_acc_lim = 16'd92;
      3'h1: dfm_acc_lim = 16'd400;
      3'h2: dfm_acc_lim = 16'd640;
      3'h3: dfm_acc_lim = 16'd1000;
      3'h4: dfm_acc_lim = 16'd138;
      3'h5: dfm_acc_lim = 16'd246;
      3'h6: dfm_acc_lim = 16'd336;
      3'h7: dfm_acc_lim = 16'd520;
    endcase
  endfunction

  function automatic logic [15:0] dfm_rej_lim(input logic [2:0] code);
    unique case (code)
      3'h0: dfm_rej_lim = 16'd120;
      3'h1: dfm_rej_lim = 16'd520;
      3'h2: dfm_rej_lim = 16'd830;
      3'h3: dfm_rej_lim = 16'd1300;
      3'h4: dfm_rej_lim = 16'd180;
      3'h5: dfm_rej_lim = 16'd320;
      3'h6: dfm_rej_lim = 16'd475;
      3'h7: dfm_rej_lim = 16'd675;
    endcase
  endfunction
endpackage

// ### verilog/dfm_win_if.sv
// carrier between the monitor top and its window comparator
`timescale 1ns/1ps
interface dfm_win_if;
  logic [2:0] sel;
  logic [15:0] ofs;
  logic prev_rej;
  logic next_rej;
  modport top (output sel, output ofs, output prev_rej, input next_rej);
  modport win (input sel, input ofs, input prev_rej, output next_rej);
endinterface

// ### verilog/dfm_window.sv
// acceptance / rejection window comparator with hysteresis
`timescale 1ns/1ps
module dfm_window (
  dfm_win_if.win w
);
  import dfm_pkg::*;

  logic in_acc;
  logic out_rej;

  // ------------------------------------------------------------
  // verdict
  // ------------------------------------------------------------
  always_comb begin
    in_acc = (w.ofs <= dfm_acc_lim(w.sel));
    out_rej = (w.ofs > dfm_rej_lim(w.sel));
    if (in_acc) begin
      w.next_rej = 1'b0;
    end else if (out_rej) begin
      w.next_rej = 1'b1;
    end else begin
      w.next_rej = w.prev_rej;
    end
  end
endmodule

// ### testbench/dfm_top_tb_top.sv
// self-checking bench of the reference frequency monitor configuration block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, (a), (b)); end end
module dfm_top_tb_top;
  import dfm_pkg::*;
  // ----------------------------------------
  // signals and tables
  // ----------------------------------------
  logic clk_i;
  logic resetn_i;
  logic wr_en_i;
  logic rd_en_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic meas_valid_i;
  logic [OFS_W-1:0] meas_ofs_i;
  logic [DATA_W-1:0] rdata_o;
  logic [OFS_W-1:0] hold_pull_lim_o;
  logic hold_pull_unlim_o;
  logic freq_reject_o;
  logic ref_fail_o;
  logic holdover_req_o;
  logic ho_b;
  logic rf_b;
  logic [7:0] rv;
  int n_errors;
  int num_checks;
  // limits in 0.1 ppm, kept apart from the design's own tables
  logic [15:0] acc_t [8] = '{16'h5c, 16'h190, 16'h280, 16'h3e8, 16'h8a, 16'hf6, 16'h150, 16'h208};
  logic [15:0] rej_t [8] = '{16'h78, 16'h208, 16'h33e, 16'h514, 16'hb4, 16'h140, 16'h1db, 16'h2a3};
  logic [15:0] hold_t [5] = '{16'h78, 16'h208, 16'h33e, 16'h514, 16'hfa0};

  dfm_top dfm_top_inst (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .meas_valid_i(meas_valid_i),
    .meas_ofs_i(meas_ofs_i),
    .rdata_o(rdata_o),
    .hold_pull_lim_o(hold_pull_lim_o),
    .hold_pull_unlim_o(hold_pull_unlim_o),
    .freq_reject_o(freq_reject_o),
    .ref_fail_o(ref_fail_o),
    .holdover_req_o(holdover_req_o)
  );

  // ----------------------------------------
  // clock, watchdog and access tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is under two hundred cycles; far margin before declaring a hang
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_en_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_i);
    #1;
    wr_en_i = 1'b0;
    if (a == OFS_HO_EN) ho_b = d[HO_EN_BIT];
    if (a == OFS_RF_EN) rf_b = d[RF_EN_BIT];
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    rd_en_i = 1'b1;
    addr_i = a;
    @(posedge clk_i);
    #1;
    rd_en_i = 1'b0;
    d = rdata_o;
  endtask

  // write, then read the same place on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    wr(a, d);
    rd_en_i = 1'b1;
    @(posedge clk_i);
    #1;
    rd_en_i = 1'b0;
    q = rdata_o;
  endtask

  // one measurement, then verdict and both gated alarms
  task automatic meas(input logic [15:0] o, input logic rej);
    @(posedge clk_i);
    #1;
    meas_valid_i = 1'b1;
    meas_ofs_i = o;
    @(posedge clk_i);
    #1;
    meas_valid_i = 1'b0;
    `CHK(freq_reject_o, rej)
    `CHK(holdover_req_o, rej & ho_b)
    `CHK(ref_fail_o, rej & rf_b)
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {wr_en_i, rd_en_i, meas_valid_i, addr_i, wdata_i, meas_ofs_i} = '0;
    {n_errors, num_checks} = '0;
    ho_b = 1'b1;
    rf_b = 1'b0;
    resetn_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    `CHK({hold_pull_unlim_o, freq_reject_o, ref_fail_o, holdover_req_o}, 4'h8)
    rd(OFS_HOLD_PULL, rv); `CHK(rv, RST_HOLD_PULL)
    rd(OFS_HO_EN, rv); `CHK(rv, RST_HO_EN)
    rd(OFS_RF_EN, rv); `CHK(rv, RST_RF_EN)
    rd(OFS_WIN_SEL, rv); `CHK(rv, RST_WIN_SEL)
    // unmapped place: write is dropped, read gives the fixed value
    wr(8'hee, 8'h5a);
    rd(8'hee, rv); `CHK(rv, RD_UNMAPPED)
    $display("test reset values done");
    for (int c = 0; c < 5; c++) begin
      wr(OFS_HOLD_PULL, {5'h00, 3'(c)});
      `CHK(hold_pull_lim_o, hold_t[c])
      `CHK(hold_pull_unlim_o, 1'b0)
    end
    // reserved codes keep the last limit
    wr(OFS_HOLD_PULL, 8'h05); `CHK({hold_pull_unlim_o, hold_pull_lim_o}, 17'h00fa0)
    wr(OFS_HOLD_PULL, 8'h06); `CHK({hold_pull_unlim_o, hold_pull_lim_o}, 17'h00fa0)
    wr(OFS_HOLD_PULL, 8'h07); `CHK(hold_pull_unlim_o, 1'b1)
    $display("test hold range done");
    for (int s = 0; s < 8; s++) begin
      // upper bits rewritten with their reset pattern
      wr_rd(OFS_WIN_SEL, {5'h06, 3'(s)}, rv);
      `CHK(rv, {5'h06, 3'(s)})
      meas(acc_t[s], 1'b0);
      meas(acc_t[s] + 16'h1, 1'b0);
      meas(rej_t[s] + 16'h1, 1'b1);
      meas(rej_t[s], 1'b1);
      meas(acc_t[s] + 16'h1, 1'b1);
      meas(acc_t[s], 1'b0);
    end
    rd(OFS_WIN_SEL, rv); `CHK(rv, 8'h37)
    $display("test windows done");
    meas(16'h2a4, 1'b1);
    wr(OFS_RF_EN, 8'h01); `CHK(ref_fail_o, 1'b1)
    wr(OFS_HO_EN, 8'he0); `CHK(holdover_req_o, 1'b0)
    `CHK(ref_fail_o, 1'b1)
    meas(16'h2a4, 1'b1);
    rd(OFS_HO_EN, rv); `CHK(rv, 8'he0)
    wr(OFS_HO_EN, 8'hf0); `CHK(holdover_req_o, 1'b1)
    wr(OFS_RF_EN, 8'h00); `CHK(ref_fail_o, 1'b0)
    meas(16'h0, 1'b0);
    $display("test alarm gating done");
    test_done();
  end
endmodule
